// ### dv/dcr_regs_monitor.sv
// Checker for bus handshake and decoded settings of the register bank
`timescale 1ns/10ps
module dcr_regs_monitor
    import dcr_pkg::*;
(
    input wire logic         REF_CLK,  // Clock
    input wire logic         RESETN,   // Reset, low
    input wire logic         CYC_I,    // Bus cycle
    input wire logic         STB_I,    // Strobe
    input wire logic         WE_I,     // Write enable
    input wire logic [11:0]  ADR_I,    // Byte address
    input wire logic [3:0]   SEL_I,    // Byte lanes
    input wire logic [31:0]  DAT_I,    // Write data
    input wire logic [31:0]  DAT_O,    // Read data
    input wire logic         ACK_O,    // Acknowledge
    input wire dcr_ch2_cfg_t CH2_CFG,  // Second channel settings
    input wire dcr_ch3_cfg_t CH3_CFG   // Third channel settings
);
    ////////////////////////////////////////////////////////////////////
    // Write accepted on byte lane 0
    logic wr;
    assign wr = CYC_I && STB_I && WE_I && ACK_O && SEL_I[0];

    // Expected decimation for a control value
    function automatic logic [4:0] dexp(input logic c, input logic [1:0] d);
        logic [4:0] r;
        r = (d == 2'h3) ? 5'h02 : (d == 2'h0) ? 5'h04 :
            (d == 2'h1) ? 5'h08 : 5'h10;
        return c ? (r >> 1) : r;
    endfunction

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////
    // Handshake and settings relations
    ack_pulse_a: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    ack_reply_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acked next cycle");
    read_upper_a: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    mixer_gain_a: assert property (wr && ADR_I == 12'hDC0 |=>
        CH3_CFG.complex_mixer == $past(DAT_I[7]) &&
        CH3_CFG.gain_6db == $past(DAT_I[6]))
        else $error("mixer or gain select wrong");
    variable_if_a: assert property (wr && ADR_I == 12'hDC0 &&
        DAT_I[5:4] == 2'h0 |=> CH3_CFG.mixer_en && CH3_CFG.oscillator_en)
        else $error("variable IF mode wrong");
    zero_if_a: assert property (wr && ADR_I == 12'hDC0 &&
        DAT_I[5:4] == 2'h1 |=> !CH3_CFG.mixer_en && !CH3_CFG.oscillator_en)
        else $error("zero IF mode wrong");
    full_scale_a: assert property (wr && ADR_I == 12'hDC0 &&
        DAT_I[5:4] == 2'h3 |=> CH3_CFG.force_full_scale &&
        CH3_CFG.oscillator_en)
        else $error("test IF mode wrong");
    quarter_rate_a: assert property (wr && ADR_I == 12'hDC0 &&
        DAT_I[5:4] == 2'h2 |=> CH3_CFG.quarter_rate_mix &&
        !CH3_CFG.force_full_scale)
        else $error("quarter rate IF mode wrong");
    decim_map_a: assert property (wr && ADR_I == 12'hDC0 |=>
        CH3_CFG.decim_ratio == dexp($past(DAT_I[3]), $past(DAT_I[1:0])))
        else $error("decimation ratio wrong");
    phase_pair_a: assert property (wr && ADR_I == 12'hE04 |=>
        CH3_CFG.phase_offset_word[11:8] == $past(DAT_I[3:0]))
        else $error("phase high nibble wrong");
    tune_low_a: assert property (wr && ADR_I == 12'hDD0 |=>
        CH3_CFG.frequency_tuning_word[7:0] == $past(DAT_I[7:0]))
        else $error("tuning low byte wrong");
    test_sel_a: assert property (wr && ADR_I == 12'hD9C |=>
        CH2_CFG.i_test_en == $past(DAT_I[0]) &&
        CH2_CFG.q_test_en == $past(DAT_I[2]))
        else $error("output test enables wrong");
    input_sel_a: assert property (wr && ADR_I == 12'hDC4 |=>
        CH3_CFG.i_from_second == $past(DAT_I[0]) &&
        CH3_CFG.q_from_second == $past(DAT_I[2]))
        else $error("input select wrong");
endmodule

bind dcr_regs dcr_regs_monitor dcr_regs_monitor_i (.REF_CLK, .RESETN,
    .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O,
    .CH2_CFG, .CH3_CFG);

// ### dv/test_dcr_regs.sv
// Self-checking bench for the downconverter register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_dcr_regs
    import dcr_pkg::*;
;
    logic         REF_CLK, RESETN, CYC_I, STB_I, WE_I, ACK_O;
    logic [11:0]  ADR_I;
    logic [3:0]   SEL_I;
    logic [31:0]  DAT_I, DAT_O, rd;
    dcr_ch2_cfg_t CH2_CFG;
    dcr_ch3_cfg_t CH3_CFG;
    int           failures = 0;
    int           checked = 0;
    logic [7:0]   v;
    localparam logic [11:0] ADR[9] = '{12'hD80, 12'hD84, 12'hD9C, 12'hDC0,
        12'hDC4, 12'hDD0, 12'hDD4, 12'hE00, 12'hE04};
    localparam logic [7:0] MSK[9] = '{8'hFF, 8'h0F, 8'h05, 8'hFB, 8'h05,
        8'hFF, 8'h0F, 8'hFF, 8'h0F};
    // Mixer, oscillator, full scale, quarter rate per IF mode
    localparam logic [3:0] MODE[4] = '{4'hC, 4'h0, 4'h9, 4'hE};

    dcr_regs dcr_regs_i (.REF_CLK, .RESETN, .CYC_I, .STB_I, .WE_I, .ADR_I,
        .SEL_I, .DAT_I, .DAT_O, .ACK_O, .CH2_CFG, .CH3_CFG);

    ////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz
    initial
    begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end

    // Verdict and end of run
    task automatic finish_test();
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One classic Wishbone cycle, waits for ack with a bound
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge REF_CLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= w;
        ADR_I <= a;
        SEL_I <= s;
        DAT_I <= {24'h0, d};
        do
        begin
            @(posedge REF_CLK);
            n++;
        end
        while (ACK_O !== 1'b1 && n < 16);
        if (n >= 16)
            failures++;
        rd = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 4'hF);
        `CHK("read data", {24'h0, e}, rd)
    endtask

    // Expected decimation ratio
    function automatic logic [4:0] dexp(input logic c, input logic [1:0] d);
        logic [4:0] r;
        r = (d == 2'h3) ? DEC_BY_2 : (d == 2'h0) ? DEC_BY_4 :
            (d == 2'h1) ? DEC_BY_8 : DEC_BY_16;
        return c ? (r >> 1) : r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #50000;
        failures++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        RESETN = 1'b0;
        CYC_I = 1'b0;
        STB_I = 1'b0;
        WE_I = 1'b0;
        ADR_I = 12'h000;
        SEL_I = 4'h0;
        DAT_I = 32'h0;
        repeat (16) @(posedge REF_CLK);
        RESETN <= 1'b1;
        for (int i = 0; i < 9; i++)
            rdchk(ADR[i], 8'h00);
        `CHK("ch2 reset", 14'h0, CH2_CFG)
        `CHK("mode reset", MODE[0], {CH3_CFG.mixer_en,
            CH3_CFG.oscillator_en, CH3_CFG.force_full_scale,
            CH3_CFG.quarter_rate_mix})
        `CHK("mixer reset", 1'b1, CH3_CFG.mixer_en)
        `CHK("decim reset", DEC_BY_4, CH3_CFG.decim_ratio)
        for (int i = 0; i < 9; i++)
        begin
            wr(ADR[i], 8'hFF);
            rdchk(ADR[i], MSK[i]);
        end
        @(posedge REF_CLK);
        `CHK("ch2 phase", 12'hFFF, CH2_CFG.phase_offset_word)
        `CHK("ch3 tune", 12'hFFF, CH3_CFG.frequency_tuning_word)
        wr(12'hE00, 8'hA5);
        wr(12'hE04, 8'h3C);
        wr(12'hDD0, 8'h5A);
        wr(12'hDD4, 8'hF7);
        wb(1'b1, 12'hDD0, 8'h00, 4'h0);
        wr(12'hD88, 8'hFF);
        @(posedge REF_CLK);
        `CHK("ch3 phase", 12'hCA5, CH3_CFG.phase_offset_word)
        `CHK("ch3 tune", 12'h75A, CH3_CFG.frequency_tuning_word)
        rdchk(12'hD88, 8'h00);
        for (int k = 0; k < 32; k++)
        begin
            v = {k[0] ^ k[3], k[1] ^ k[4], k[4:3], k[2], 1'b0, k[1:0]};
            wr(12'hDC0, v);
            @(posedge REF_CLK);
            `CHK("mixer", v[7], CH3_CFG.complex_mixer)
            `CHK("gain", v[6], CH3_CFG.gain_6db)
            `CHK("c2r", v[3], CH3_CFG.c2r_en)
            `CHK("decim", dexp(v[3], v[1:0]), CH3_CFG.decim_ratio)
            `CHK("if mode", MODE[v[5:4]], {CH3_CFG.mixer_en,
                CH3_CFG.oscillator_en, CH3_CFG.force_full_scale,
                CH3_CFG.quarter_rate_mix})
        end
        for (int k = 0; k < 4; k++)
        begin
            v = {5'h00, k[1], 1'b0, k[0]};
            wr(12'hDC4, v | 8'hFA);
            wr(12'hD9C, v | 8'hFA);
            @(posedge REF_CLK);
            `CHK("i source", v[0], CH3_CFG.i_from_second)
            `CHK("q source", v[2], CH3_CFG.q_from_second)
            `CHK("q test", v[2], CH2_CFG.q_test_en)
            `CHK("i test", v[0], CH2_CFG.i_test_en)
            rdchk(12'hD9C, v);
        end
        // Mid-run reset clears every register
        @(posedge REF_CLK);
        RESETN <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        RESETN <= 1'b1;
        for (int i = 0; i < 9; i++)
            rdchk(ADR[i], 8'h00);
        `CHK("decim again", DEC_BY_4, CH3_CFG.decim_ratio)
        finish_test();
    end
endmodule

// ### hw/dcr_reg8.sv
// One 8-bit configuration register with a writable-bit mask
`timescale 1ns/10ps
module dcr_reg8
    import dcr_pkg::*;
#(
    parameter logic [7:0] WMASK = 8'hFF
)
(
    input  wire logic       clk,      // System clock
    input  wire logic       rst_n,    // Synchronous reset, low
    input  wire logic       wr_en,    // Write strobe
    input  wire logic [7:0] wr_data,  // Write data
    output logic      [7:0] q         // Stored value
);

    logic [7:0] val_q;
    logic [7:0] val_d;

    // Masked bits stay zero whatever is written
    always_comb
    begin
        val_d = val_q;
        if (wr_en)
        begin
            val_d = wr_data & WMASK;
        end
    end

    // Register with reset to all zeros
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            val_q <= REG_RESET;
        end
        else
        begin
            val_q <= val_d;
        end
    end

    assign q = val_q;

endmodule

// ### hw/dcr_regs.sv
// Downconverter configuration register bank on a Wishbone slave
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
module dcr_regs
    import dcr_pkg::*;
(
    input  wire logic        REF_CLK,  // 200 MHz clock
    input  wire logic        RESETN,   // Synchronous reset, low
    input  wire logic        CYC_I,    // Bus cycle
    input  wire logic        STB_I,    // Strobe
    input  wire logic        WE_I,     // Write enable
    input  wire logic [11:0] ADR_I,    // Byte address
    input  wire logic [3:0]  SEL_I,    // Byte lanes
    input  wire logic [31:0] DAT_I,    // Write data
    output logic      [31:0] DAT_O,    // Read data
    output logic             ACK_O,    // Acknowledge
    output dcr_ch2_cfg_t     CH2_CFG,  // Second channel settings
    output dcr_ch3_cfg_t     CH3_CFG   // Third channel settings
);

    ////////////////////////////////////////////////////////////////////
    // Bus request decode

    logic [9:0] word_idx;
    logic       req;
    logic       take;
    logic       wr_lane0;
    logic       ack_q;
    logic       ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;

    // Word index from the byte address
    // Byte lanes 1 to 3 and address bits 1:0 are not decoded
    assign word_idx = ADR_I[11:2];

    // A request is taken once, on the edge that raises ack
    // Gating on ack_q keeps a held strobe from writing twice
    assign req  = CYC_I & STB_I;
    assign take = req & ~ack_q;

    // Registers live in lane 0 only
    assign wr_lane0 = take & WE_I & SEL_I[0];

    ////////////////////////////////////////////////////////////////////
    // Per-register write strobes

    logic we_ch2_ph_lo;
    logic we_ch2_ph_hi;
    logic we_ch2_test;
    logic we_ch3_ctrl;
    logic we_ch3_insel;
    logic we_ch3_tu_lo;
    logic we_ch3_tu_hi;
    logic we_ch3_ph_lo;
    logic we_ch3_ph_hi;

    // Address match per register; unmapped writes are dropped
    // Unmapped writes are still acked so the master never stalls
    assign we_ch2_ph_lo = wr_lane0 & (word_idx == IDX_CH2_PHASE_LO);
    assign we_ch2_ph_hi = wr_lane0 & (word_idx == IDX_CH2_PHASE_HI);
    assign we_ch2_test  = wr_lane0 & (word_idx == IDX_CH2_TEST_SEL);
    assign we_ch3_ctrl  = wr_lane0 & (word_idx == IDX_CH3_CONTROL);
    assign we_ch3_insel = wr_lane0 & (word_idx == IDX_CH3_INPUT_SEL);
    assign we_ch3_tu_lo = wr_lane0 & (word_idx == IDX_CH3_TUNE_LO);
    assign we_ch3_tu_hi = wr_lane0 & (word_idx == IDX_CH3_TUNE_HI);
    assign we_ch3_ph_lo = wr_lane0 & (word_idx == IDX_CH3_PHASE_LO);
    assign we_ch3_ph_hi = wr_lane0 & (word_idx == IDX_CH3_PHASE_HI);

    ////////////////////////////////////////////////////////////////////
    // Register storage
    // Each byte has its own writable-bit mask; fixed bits stay zero

    logic [7:0] ch2_phase_offset_low;
    logic [7:0] ch2_phase_offset_high;
    logic [7:0] ch2_output_test_select;
    logic [7:0] ch3_control;
    logic [7:0] ch3_input_select;
    logic [7:0] ch3_tuning_low;
    logic [7:0] ch3_tuning_high;
    logic [7:0] ch3_phase_offset_low;
    logic [7:0] ch3_phase_offset_high;

    // Second channel phase offset, low byte
    dcr_reg8 #(.WMASK(MASK_FULL)) u_ch2_ph_lo
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch2_ph_lo),
        .wr_data (DAT_I[7:0]),
        .q       (ch2_phase_offset_low)
    );

    // Second channel phase offset, high nibble
    dcr_reg8 #(.WMASK(MASK_NIBBLE)) u_ch2_ph_hi
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch2_ph_hi),
        .wr_data (DAT_I[7:0]),
        .q       (ch2_phase_offset_high)
    );

    // Second channel output test enables
    dcr_reg8 #(.WMASK(MASK_TEST)) u_ch2_test
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch2_test),
        .wr_data (DAT_I[7:0]),
        .q       (ch2_output_test_select)
    );

    // Third channel control
    dcr_reg8 #(.WMASK(MASK_CTRL)) u_ch3_ctrl
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch3_ctrl),
        .wr_data (DAT_I[7:0]),
        .q       (ch3_control)
    );

    // Third channel input selection
    dcr_reg8 #(.WMASK(MASK_INSEL)) u_ch3_insel
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch3_insel),
        .wr_data (DAT_I[7:0]),
        .q       (ch3_input_select)
    );

    // Third channel tuning word, low byte
    dcr_reg8 #(.WMASK(MASK_FULL)) u_ch3_tu_lo
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch3_tu_lo),
        .wr_data (DAT_I[7:0]),
        .q       (ch3_tuning_low)
    );

    // Third channel tuning word, high nibble
    dcr_reg8 #(.WMASK(MASK_NIBBLE)) u_ch3_tu_hi
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch3_tu_hi),
        .wr_data (DAT_I[7:0]),
        .q       (ch3_tuning_high)
    );

    // Third channel phase offset, low byte
    dcr_reg8 #(.WMASK(MASK_FULL)) u_ch3_ph_lo
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch3_ph_lo),
        .wr_data (DAT_I[7:0]),
        .q       (ch3_phase_offset_low)
    );

    // Third channel phase offset, high nibble
    dcr_reg8 #(.WMASK(MASK_NIBBLE)) u_ch3_ph_hi
    (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .wr_en   (we_ch3_ph_hi),
        .wr_data (DAT_I[7:0]),
        .q       (ch3_phase_offset_high)
    );

    ////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge

    logic [7:0] rd_byte;

    // Unmapped addresses read as zero
    // Read data is registered so DAT_O comes from a flip-flop
    always_comb
    begin
        unique case (word_idx)
            IDX_CH2_PHASE_LO:  rd_byte = ch2_phase_offset_low;
            IDX_CH2_PHASE_HI:  rd_byte = ch2_phase_offset_high;
            IDX_CH2_TEST_SEL:  rd_byte = ch2_output_test_select;
            IDX_CH3_CONTROL:   rd_byte = ch3_control;
            IDX_CH3_INPUT_SEL: rd_byte = ch3_input_select;
            IDX_CH3_TUNE_LO:   rd_byte = ch3_tuning_low;
            IDX_CH3_TUNE_HI:   rd_byte = ch3_tuning_high;
            IDX_CH3_PHASE_LO:  rd_byte = ch3_phase_offset_low;
            IDX_CH3_PHASE_HI:  rd_byte = ch3_phase_offset_high;
            default:           rd_byte = 8'h00;
        endcase
    end

    // Ack one cycle after the request, then drop for one cycle
    always_comb
    begin
        ack_d = take;
        dat_d = dat_q;
        if (take && !WE_I)
        begin
            dat_d = {24'h000000, rd_byte};
        end
        else if (take)
        begin
            dat_d = 32'h00000000;
        end
    end

    // Bus answer registers
    // ack_q also blocks the next take for one cycle
    always_ff @(posedge REF_CLK)
    begin
        if (!RESETN)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign ACK_O = ack_q;
    assign DAT_O = dat_q;

    ////////////////////////////////////////////////////////////////////
    // Decode of the register fields into channel settings
    // Settings lag the register contents by one clock

    dcr_ch2_cfg_t ch2_q;
    dcr_ch2_cfg_t ch2_d;
    dcr_ch3_cfg_t ch3_q;
    dcr_ch3_cfg_t ch3_d;
    logic [1:0]   if_mode;
    logic [1:0]   dec_code;

    assign if_mode  = ch3_control[CTL_IF_HI:CTL_IF_LO];
    assign dec_code = ch3_control[CTL_DEC_HI:CTL_DEC_LO];

    // Second channel: phase word and output test enables
    always_comb
    begin
        ch2_d = ch2_q;
        ch2_d.phase_offset_word = {ch2_phase_offset_high[3:0],
                                   ch2_phase_offset_low};
        ch2_d.i_test_en = ch2_output_test_select[TEST_I_BIT];
        ch2_d.q_test_en = ch2_output_test_select[TEST_Q_BIT];
    end

    // Third channel: words, mixer, gain and input routing
    always_comb
    begin
        ch3_d = ch3_q;
        ch3_d.phase_offset_word = {ch3_phase_offset_high[3:0],
                                   ch3_phase_offset_low};
        ch3_d.frequency_tuning_word = {ch3_tuning_high[3:0],
                                       ch3_tuning_low};
        ch3_d.complex_mixer = ch3_control[CTL_MIXER];
        ch3_d.gain_6db      = ch3_control[CTL_GAIN];
        ch3_d.c2r_en        = ch3_control[CTL_C2R];
        ch3_d.i_from_second = ch3_input_select[SEL_I_BIT];
        ch3_d.q_from_second = ch3_input_select[SEL_Q_BIT];

        // IF mode sets mixer path and oscillator state
        // Quarter-rate mixing needs no oscillator, so it is switched off
        unique case (if_mode)
            IF_VARIABLE:
            begin
                ch3_d.mixer_en         = 1'b1;
                ch3_d.oscillator_en    = 1'b1;
                ch3_d.force_full_scale = 1'b0;
                ch3_d.quarter_rate_mix = 1'b0;
            end
            IF_ZERO:
            begin
                ch3_d.mixer_en         = 1'b0;
                ch3_d.oscillator_en    = 1'b0;
                ch3_d.force_full_scale = 1'b0;
                ch3_d.quarter_rate_mix = 1'b0;
            end
            IF_QUARTER:
            begin
                ch3_d.mixer_en         = 1'b1;
                ch3_d.oscillator_en    = 1'b0;
                ch3_d.force_full_scale = 1'b0;
                ch3_d.quarter_rate_mix = 1'b1;
            end
            IF_TEST_FS:
            begin
                ch3_d.mixer_en         = 1'b1;
                ch3_d.oscillator_en    = 1'b1;
                ch3_d.force_full_scale = 1'b1;
                ch3_d.quarter_rate_mix = 1'b0;
            end
        endcase

        // Decimation ratio halves when complex-to-real is on
        unique case (dec_code)
            DEC_CODE_A:
                ch3_d.decim_ratio = ch3_control[CTL_C2R] ? DEC_BY_1
                                                          : DEC_BY_2;
            DEC_CODE_B:
                ch3_d.decim_ratio = ch3_control[CTL_C2R] ? DEC_BY_2
                                                          : DEC_BY_4;
            DEC_CODE_C:
                ch3_d.decim_ratio = ch3_control[CTL_C2R] ? DEC_BY_4
                                                          : DEC_BY_8;
            DEC_CODE_D:
                ch3_d.decim_ratio = ch3_control[CTL_C2R] ? DEC_BY_8
                                                          : DEC_BY_16;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registered settings outputs

    // Reset state matches the all-zero registers decoded
    // Variable IF and decimate by four follow from all-zero fields
    always_ff @(posedge REF_CLK)
    begin
        if (!RESETN)
        begin
            ch2_q <= '0;
            ch3_q <= '0;
            ch3_q.mixer_en      <= 1'b1;
            ch3_q.oscillator_en <= 1'b1;
            ch3_q.decim_ratio   <= DEC_BY_4;
        end
        else
        begin
            ch2_q <= ch2_d;
            ch3_q <= ch3_d;
        end
    end

    assign CH2_CFG = ch2_q;
    assign CH3_CFG = ch3_q;

endmodule

// ### include/dcr_pkg.sv
// Constants and types for the downconverter configuration register bank
package dcr_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CH2_PHASE_LO  = 10'h360;
    localparam logic [9:0] IDX_CH2_PHASE_HI  = 10'h361;
    localparam logic [9:0] IDX_CH2_TEST_SEL  = 10'h367;
    localparam logic [9:0] IDX_CH3_CONTROL   = 10'h370;
    localparam logic [9:0] IDX_CH3_INPUT_SEL = 10'h371;
    localparam logic [9:0] IDX_CH3_TUNE_LO   = 10'h374;
    localparam logic [9:0] IDX_CH3_TUNE_HI   = 10'h375;
    localparam logic [9:0] IDX_CH3_PHASE_LO  = 10'h380;
    localparam logic [9:0] IDX_CH3_PHASE_HI  = 10'h381;

    ////////////////////////////////////////////////////////////////////
    // Reset value and writable-bit masks
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] MASK_FULL   = 8'hFF;
    localparam logic [7:0] MASK_NIBBLE = 8'h0F;
    localparam logic [7:0] MASK_TEST   = 8'h05;
    localparam logic [7:0] MASK_CTRL   = 8'hFB;
    localparam logic [7:0] MASK_INSEL  = 8'h05;

    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTL_MIXER  = 7;
    localparam int CTL_GAIN   = 6;
    localparam int CTL_IF_HI  = 5;
    localparam int CTL_IF_LO  = 4;
    localparam int CTL_C2R    = 3;
    localparam int CTL_DEC_HI = 1;
    localparam int CTL_DEC_LO = 0;
    localparam int SEL_I_BIT  = 0;
    localparam int SEL_Q_BIT  = 2;
    localparam int TEST_I_BIT = 0;
    localparam int TEST_Q_BIT = 2;

    ////////////////////////////////////////////////////////////////////
    // IF mode and decimation field codes
    localparam logic [1:0] IF_VARIABLE = 2'h0;
    localparam logic [1:0] IF_ZERO     = 2'h1;
    localparam logic [1:0] IF_QUARTER  = 2'h2;
    localparam logic [1:0] IF_TEST_FS  = 2'h3;
    localparam logic [1:0] DEC_CODE_A  = 2'h3;
    localparam logic [1:0] DEC_CODE_B  = 2'h0;
    localparam logic [1:0] DEC_CODE_C  = 2'h1;
    localparam logic [1:0] DEC_CODE_D  = 2'h2;
    localparam logic [4:0] DEC_BY_1    = 5'h01;
    localparam logic [4:0] DEC_BY_2    = 5'h02;
    localparam logic [4:0] DEC_BY_4    = 5'h04;
    localparam logic [4:0] DEC_BY_8    = 5'h08;
    localparam logic [4:0] DEC_BY_16   = 5'h10;

    ////////////////////////////////////////////////////////////////////
    // Decoded channel settings
    typedef struct packed {
        logic [11:0] phase_offset_word;
        logic        i_test_en;
        logic        q_test_en;
    } dcr_ch2_cfg_t;

    typedef struct packed {
        logic [11:0] phase_offset_word;
        logic [11:0] frequency_tuning_word;
        logic        complex_mixer;
        logic        gain_6db;
        logic        mixer_en;
        logic        oscillator_en;
        logic        force_full_scale;
        logic        quarter_rate_mix;
        logic        c2r_en;
        logic [4:0]  decim_ratio;
        logic        i_from_second;
        logic        q_from_second;
    } dcr_ch3_cfg_t;

endpackage
